// [bl_pkg.sv]
`default_nettype none
package bl_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int unsigned NREG   = 32;
   localparam int unsigned PTR_W  = 16;
   localparam int unsigned DATA_W = 8;

   // ------------------------------------------------------------------
   // register map (byte offsets, low address byte)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_OPCODE  = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_FLAGS   = 8'h08;
   localparam logic [7:0] OFS_PC      = 8'h0C;
   localparam logic [7:0] OFS_REGFILE = 8'h40;
   localparam logic [7:0] OFS_REG_END = 8'hC0;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] RST_PC     = 16'h0000;
   localparam logic [7:0]  RST_FLAGS  = 8'h00;
   localparam logic [15:0] RST_OPCODE = 16'h0000;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_N = 2;
   localparam int unsigned FLG_V = 3;
   localparam int unsigned FLG_S = 4;
   localparam int unsigned STS_BUSY    = 0;
   localparam int unsigned STS_TAKEN   = 1;
   localparam int unsigned STS_ILLEGAL = 2;

   // pointer pairs: low byte register index
   localparam logic [4:0] PTR_X = 5'h1A;
   localparam logic [4:0] PTR_Y = 5'h1C;
   localparam logic [4:0] PTR_Z = 5'h1E;

   // ------------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {PM_PLAIN, PM_POSTINC, PM_PREDEC, PM_DISP} ptr_mode_t;
   typedef enum logic [2:0] {
      OC_ILLEGAL, OC_BRANCH, OC_COPY, OC_PAIR_COPY, OC_CONST, OC_LOAD, OC_STORE
   } op_class_t;

endpackage
`default_nettype wire

// [ptr_if.sv]
`timescale 1ns/1ps
`default_nettype none
// pointer pair request and resulting access address
interface ptr_if import bl_pkg::*; ();
   logic [15:0] ptr;
   ptr_mode_t   mode;
   logic [5:0]  disp;
   logic [15:0] addr;
   logic [15:0] next_ptr;
   modport core (output ptr, output mode, output disp, input addr, input next_ptr);
   modport unit (input ptr, input mode, input disp, output addr, output next_ptr);
endinterface
`default_nettype wire

// [ptr_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module ptr_unit import bl_pkg::*; (
   // pointer request
   ptr_if.unit pif
);
   // access address and pointer write-back per addressing mode
   always_comb begin
      pif.addr     = pif.ptr;
      pif.next_ptr = pif.ptr;
      unique case (pif.mode)
         PM_PLAIN: begin
            pif.addr = pif.ptr;
         end
         PM_POSTINC: begin
            pif.next_ptr = pif.ptr + 16'h0001;
         end
         PM_PREDEC: begin
            pif.addr     = pif.ptr - 16'h0001;
            pif.next_ptr = pif.ptr - 16'h0001;
         end
         PM_DISP: begin
            pif.addr = pif.ptr + {10'h000, pif.disp};
         end
      endcase
   end
endmodule // ptr_unit
`default_nettype wire

// [cond_eval.sv]
`timescale 1ns/1ps
`default_nettype none
module cond_eval import bl_pkg::*; (
   // flag state and selection
   input  wire logic [7:0] flags,
   input  wire logic [2:0] bit_sel,
   input  wire logic       on_clear,
   // result
   output logic            taken
);
   logic flag;

   // signed test uses n xor v, the rest a single flag
   always_comb begin
      if (bit_sel == 3'(FLG_S)) begin
         flag = flags[FLG_N] ^ flags[FLG_V];
      end else begin
         flag = flags[bit_sel];
      end
      taken = flag ^ on_clear;
   end
endmodule // cond_eval
`default_nettype wire

// [branch_and_load_execution.sv]
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - carry-set branch jumps to pc+k+1 when c=1, carry-clear when c=0.
// - unsigned same-or-higher taken when c=0, unsigned lower when c=1.
// - negative branch taken when n=1, positive branch when n=0.
// - signed ge taken when n xor v is 0, signed lt when 1.
// - half-carry set branch taken when h=1, clear branch when h=0.
// - transfer-bit set branch taken when t=1, clear branch when t=0.
// - irq-enabled branch taken when i=1, irq-disabled branch when i=0.
// - copy moves source to destination; pair copy moves both bytes at once.
// - load constant writes the instruction's constant into the destination.
// - post-increment load reads at the pointer, then adds one to it.
// - pre-decrement load subtracts one from the pointer, then reads there.
// - displacement load reads at y or z plus q; pointer unchanged.
// - stores write the source at the pointer; inc after, dec before.
// - no instruction of this group alters any status flag.
module branch_and_load_execution import bl_pkg::*; (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // data memory
   output logic [15:0]      dmem_addr,
   output logic [7:0]       dmem_wdata,
   output logic             dmem_re,
   output logic             dmem_we,
   input  wire logic [7:0]  dmem_rdata
);

   typedef enum {ST_IDLE, ST_EXEC, ST_FINISH} state_t;

   state_t      state;
   logic [15:0] opcode;
   logic [7:0]  flags;
   logic [15:0] pc;
   logic [7:0]  regs [NREG];
   logic        taken_last;
   logic        illegal_last;
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  a_addr;
   logic        load_pend;
   logic [4:0]  load_dst;

   op_class_t   oc;
   ptr_mode_t   pmode;
   logic [4:0]  pbase;
   logic [5:0]  disp;
   logic [4:0]  rd;
   logic [4:0]  rr;
   logic        cond_taken;
   logic [15:0] target;
   logic        busy;
   logic        bus_wr;
   logic        reg_hit;
   logic [7:0]  reg_ofs;
   logic [31:0] next_rdata;
   logic        start;

   ptr_if pif ();

   // -------------------------------------------------------------------
   // ahb-lite slave
   // -------------------------------------------------------------------

   // address phase capture; reads take one wait state so writes settle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         a_addr  <= 8'h00;
      end else if (hsel && hready && htrans[1]) begin
         wr_pend <= hwrite;
         rd_pend <= !hwrite;
         a_addr  <= {haddr[7:2], 2'b00};
      end else begin
         wr_pend <= 1'b0;
         if (hreadyout == 1'b0) begin
            rd_pend <= 1'b0;
         end
      end
   end

   // ready, response and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'b0;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         hreadyout <= 1'b0;
      end else if (rd_pend && !hreadyout) begin
         hreadyout <= 1'b1;
         hrdata    <= next_rdata;
      end
   end

   assign busy    = (state != ST_IDLE);
   assign bus_wr  = wr_pend && !busy;
   assign reg_ofs = a_addr - OFS_REGFILE;
   assign reg_hit = (a_addr >= OFS_REGFILE) && (a_addr < OFS_REG_END);
   assign start   = bus_wr && (a_addr == OFS_OPCODE);

   // read multiplexer, unmapped words read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_hit) begin
         next_rdata = {24'h000000, regs[reg_ofs[6:2]]};
      end else begin
         unique case (a_addr)
            OFS_OPCODE: next_rdata = {16'h0000, opcode};
            OFS_STATUS: begin
               next_rdata[STS_BUSY]    = busy;
               next_rdata[STS_TAKEN]   = taken_last;
               next_rdata[STS_ILLEGAL] = illegal_last;
            end
            OFS_FLAGS:  next_rdata = {24'h000000, flags};
            OFS_PC:     next_rdata = {16'h0000, pc};
            default:    next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // instruction decode
   // -------------------------------------------------------------------

   // class, operands and pointer mode from the opcode word
   always_comb begin
      oc    = OC_ILLEGAL;
      pmode = PM_PLAIN;
      pbase = PTR_X;
      disp  = 6'h00;
      rd    = opcode[8:4];
      rr    = {opcode[9], opcode[3:0]};
      if (opcode[15:11] == 5'b11110) begin
         oc = OC_BRANCH;
      end else if (opcode[15:10] == 6'b001011) begin
         oc = OC_COPY;
      end else if (opcode[15:8] == 8'h01) begin
         oc = OC_PAIR_COPY;
      end else if (opcode[15:12] == 4'hE) begin
         oc = OC_CONST;
         rd = {1'b1, opcode[7:4]};
      end else if (opcode[15:10] == 6'b100100) begin
         oc = opcode[9] ? OC_STORE : OC_LOAD;
         unique case (opcode[3:0])
            4'hC: pmode = PM_PLAIN;
            4'hD: pmode = PM_POSTINC;
            4'hE: pmode = PM_PREDEC;
            4'h9: begin pbase = PTR_Y; pmode = PM_POSTINC; end
            4'hA: begin pbase = PTR_Y; pmode = PM_PREDEC; end
            4'h1: begin pbase = PTR_Z; pmode = PM_POSTINC; end
            4'h2: begin pbase = PTR_Z; pmode = PM_PREDEC; end
            default: oc = OC_ILLEGAL;
         endcase
      end else if (opcode[15:14] == 2'b10 && !opcode[12]) begin
         oc    = opcode[9] ? OC_STORE : OC_LOAD;
         pbase = opcode[3] ? PTR_Y : PTR_Z;
         pmode = PM_DISP;
         disp  = {opcode[13], opcode[11:10], opcode[2:0]};
      end
   end

   assign pif.ptr  = {regs[pbase + 5'h01], regs[pbase]};
   assign pif.mode = pmode;
   assign pif.disp = disp;
   // relative target, signed 7-bit k
   assign target   = pc + {{9{opcode[9]}}, opcode[9:3]} + 16'h0001;

   ptr_unit u_ptr (
      .pif (pif.unit)
   );

   cond_eval u_cond (
      .flags    (flags),
      .bit_sel  (opcode[2:0]),
      .on_clear (opcode[10]),
      .taken    (cond_taken)
   );

   // -------------------------------------------------------------------
   // sequencing
   // -------------------------------------------------------------------

   // taken branch and memory access spend a finish cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: if (start) state <= ST_EXEC;
            ST_EXEC: begin
               if ((oc == OC_BRANCH && cond_taken) || oc == OC_LOAD || oc == OC_STORE) begin
                  state <= ST_FINISH;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_FINISH: state <= ST_IDLE;
         endcase
      end
   end

   // opcode, flags and outcome bits; flags change by software only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcode       <= RST_OPCODE;
         flags        <= RST_FLAGS;
         taken_last   <= 1'b0;
         illegal_last <= 1'b0;
      end else begin
         if (start) opcode <= hwdata[15:0];
         if (bus_wr && a_addr == OFS_FLAGS) flags <= hwdata[7:0];
         if (state == ST_EXEC) begin
            taken_last   <= (oc == OC_BRANCH) && cond_taken;
            illegal_last <= (oc == OC_ILLEGAL);
         end
      end
   end

   // program counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc <= RST_PC;
      end else if (bus_wr && a_addr == OFS_PC) begin
         pc <= hwdata[15:0];
      end else if (state == ST_EXEC) begin
         if (oc == OC_BRANCH && cond_taken) begin
            pc <= target;
         end else begin
            pc <= pc + 16'h0001;
         end
      end
   end

   // register file: software, moves, pointer write-back, load return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NREG; i++) regs[i] <= 8'h00;
      end else if (bus_wr && reg_hit) begin
         regs[reg_ofs[6:2]] <= hwdata[7:0];
      end else if (state == ST_EXEC) begin
         unique case (oc)
            OC_COPY: regs[rd] <= regs[rr];
            OC_PAIR_COPY: begin
               regs[{opcode[7:4], 1'b0}] <= regs[{opcode[3:0], 1'b0}];
               regs[{opcode[7:4], 1'b1}] <= regs[{opcode[3:0], 1'b1}];
            end
            OC_CONST: regs[rd] <= {opcode[11:8], opcode[3:0]};
            OC_LOAD, OC_STORE: begin
               if (pmode == PM_POSTINC || pmode == PM_PREDEC) begin
                  regs[pbase]         <= pif.next_ptr[7:0];
                  regs[pbase + 5'h01] <= pif.next_ptr[15:8];
               end
            end
            default: ;
         endcase
      end else if (state == ST_FINISH && load_pend) begin
         regs[load_dst] <= dmem_rdata;
      end
   end

   // memory request stands for the finish cycle only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dmem_addr  <= 16'h0000;
         dmem_wdata <= 8'h00;
         dmem_re    <= 1'b0;
         dmem_we    <= 1'b0;
         load_pend  <= 1'b0;
         load_dst   <= 5'h00;
      end else if (state == ST_EXEC && (oc == OC_LOAD || oc == OC_STORE)) begin
         dmem_addr  <= pif.addr;
         dmem_wdata <= regs[rd];
         dmem_re    <= (oc == OC_LOAD);
         dmem_we    <= (oc == OC_STORE);
         load_pend  <= (oc == OC_LOAD);
         load_dst   <= rd;
      end else begin
         dmem_re   <= 1'b0;
         dmem_we   <= 1'b0;
         load_pend <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_carry_taken: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h0
       && (flags[FLG_C] ^ opcode[10])) |=> pc == $past(target))
      else $error("carry branch missed its target");
   a_carry_fallthru: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h0
       && !(flags[FLG_C] ^ opcode[10])) |=> pc == $past(pc) + 16'h0001 && state == ST_IDLE)
      else $error("carry branch not sequential");
   a_negative_branch: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h2)
      |=> (state == ST_FINISH) == $past(flags[FLG_N] ^ opcode[10]))
      else $error("negative branch decision wrong");
   a_signed_branch: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h4
       && (flags[FLG_N] ^ flags[FLG_V] ^ opcode[10])) |=> pc == $past(target))
      else $error("signed branch not taken");
   a_halfcarry_branch: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h5)
      |=> taken_last == $past(flags[5] ^ opcode[10]))
      else $error("half carry branch decision wrong");
   a_transfer_branch: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h6)
      |=> taken_last == $past(flags[6] ^ opcode[10]))
      else $error("transfer bit branch decision wrong");
   a_irq_branch: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && opcode[2:0] == 3'h7 && (flags[7] ^ opcode[10]))
      |=> pc == $past(target))
      else $error("irq branch missed its target");
   a_branch_length: assert property (
      (state == ST_EXEC && oc == OC_BRANCH && cond_taken) |=> state == ST_FINISH ##1 !busy)
      else $error("taken branch not two cycles");
   a_copy_value: assert property (
      (state == ST_EXEC && oc == OC_COPY) |=> regs[$past(rd)] == $past(regs[rr]))
      else $error("copy wrote wrong value");
   a_const_value: assert property (
      (state == ST_EXEC && oc == OC_CONST)
      |=> regs[$past(rd)] == $past({opcode[11:8], opcode[3:0]}))
      else $error("constant load wrong");
   a_postinc_load: assert property (
      (state == ST_EXEC && oc == OC_LOAD && pmode == PM_POSTINC)
      |=> dmem_re && dmem_addr == $past(pif.ptr) && pif.ptr == $past(pif.ptr) + 16'h0001)
      else $error("post increment load wrong");
   a_predec_load: assert property (
      (state == ST_EXEC && oc == OC_LOAD && pmode == PM_PREDEC)
      |=> dmem_re && dmem_addr == $past(pif.ptr) - 16'h0001 ##1 regs[load_dst] == $past(dmem_rdata))
      else $error("pre decrement load wrong");
   a_disp_load: assert property (
      (state == ST_EXEC && oc == OC_LOAD && pmode == PM_DISP)
      |=> dmem_addr == $past(pif.ptr) + {10'h000, $past(disp)} && $stable(pif.ptr))
      else $error("displacement load wrong");
   a_store_data: assert property (
      (state == ST_EXEC && oc == OC_STORE) |=> dmem_we && dmem_wdata == $past(regs[rd]) ##1 !dmem_we)
      else $error("store data wrong");
   a_flags_stable: assert property (
      busy |=> $stable(flags))
      else $error("flags changed by execution");
   a_simple_length: assert property (
      (state == ST_EXEC && (oc == OC_COPY || oc == OC_PAIR_COPY || oc == OC_CONST)) |=> !busy)
      else $error("simple instruction not one cycle");

endmodule // branch_and_load_execution
`default_nettype wire

// [dmem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// data memory at the far side of the core
// ------------------------------------------------------------
module dmem_model (
   // clock
   input  wire logic        hclk,
   // core side
   input  wire logic [15:0] dmem_addr,
   input  wire logic [7:0]  dmem_wdata,
   input  wire logic        dmem_re,
   input  wire logic        dmem_we,
   output logic [7:0]       dmem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'hA5;
   // write at the edge ending the strobe cycle
   always @(posedge hclk) begin
      if (dmem_we) begin
         mem[dmem_addr] <= dmem_wdata;
      end
      last <= dmem_rdata;
   end
   // same-cycle read; off the strobe the line flips every cycle
   assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~last;
endmodule // dmem_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench: bus driver, note queues and output monitor
// ------------------------------------------------------------
module tb import bl_pkg::*;;
   logic        hclk = 0;
   logic        hresetn = 0;
   logic        hsel = 1;
   logic [31:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic        hwrite = 0;
   logic [31:0] hwdata = 0;
   logic        hreadyout, dmem_re, dmem_we, hresp, rd_ph = 0;
   logic [31:0] hrdata, cyc = 0, op_cyc = 0;
   logic [15:0] dmem_addr;
   logic [7:0]  dmem_wdata, dmem_rdata;
   logic [32:0] q [$];
   logic [28:0] mq [$];
   int          failures = 0, check_count = 0;
   branch_and_load_execution u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_re(dmem_re),
      .dmem_we(dmem_we), .dmem_rdata(dmem_rdata));
   dmem_model u_mem (.hclk(hclk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
      .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_rdata(dmem_rdata));
   // clock
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   task automatic complete_run;
      // a noted memory access that never came counts as a mismatch
      if (mq.size() != 0) failures++;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value hrdata expected %h seen %h", e, g);
      end
   endtask
   task automatic cmp_mem(input logic [28:0] e, input logic [28:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value dmem access expected %h seen %h", e, g);
      end
   endtask
   task automatic cmp_resp(input logic g);
      check_count++;
      if (g !== 1'b0) begin
         failures++;
         $display("wrong value hresp expected 0 seen %b", g);
      end
   endtask
   // cycle count and hang limit
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 32'd20000) begin
         failures++;
         complete_run();
      end
   end
   // monitor: read data and memory strobes against the oldest notes
   always @(posedge hclk) begin
      logic [32:0] n;
      logic [31:0] dl;
      dl = cyc - op_cyc;
      if (rd_ph && hreadyout === 1'b1 && q.size() > 0) begin
         n = q.pop_front();
         if (n[32]) cmp_reg(n[31:0], hrdata);
         cmp_resp(hresp); // response is always okay
      end
      if (dmem_re === 1'b1 || dmem_we === 1'b1) begin
         if (mq.size() == 0) mq.push_back(29'h0);
         cmp_mem(mq.pop_front(), {dl[3:0], dmem_we, dmem_addr,
            dmem_we ? dmem_wdata : 8'h00});
      end
      if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e,
                     output logic [31:0] v);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      q.push_back({c, e});
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      v = hrdata;
   endtask
   function automatic logic [7:0] ra(input int r);
      return OFS_REGFILE + 8'(4 * r);
   endfunction
   task automatic ck(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, 1'b1, e, v);
   endtask
   task automatic wreg(input int r, input logic [7:0] d);
      wr(ra(r), {24'h0, d});
   endtask
   task automatic exec(input logic [15:0] op);
      logic [31:0] v;
      int n;
      wr(OFS_OPCODE, {16'h0, op});
      op_cyc = cyc;
      n = 0;
      do begin
         rd(OFS_STATUS, 1'b0, 32'h0, v);
         n++;
      end while (v[0] !== 1'b0 && n < 50);
   endtask
   // main sequence
   initial begin
      static logic [2:0] bl [6] = '{3'd0, 3'd2, 3'd4, 3'd5, 3'd6, 3'd7};
      static logic [3:0] mc [7] = '{4'hC, 4'hD, 4'hE, 4'h9, 4'hA, 4'h1, 4'h2};
      static int         pk [9] = '{26, 26, 26, 28, 28, 30, 30, 28, 30};
      static int         md [9] = '{0, 1, 2, 1, 2, 1, 2, 0, 0};
      logic [7:0]  fl, v, v2;
      logic [15:0] pc0, pc, a, ea, np, op;
      logic [6:0]  k;
      logic [5:0]  qd;
      logic        tk;
      int          rs, dd, p;
      void'($urandom(17));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ck(OFS_OPCODE, 32'h0);
      ck(OFS_STATUS, 32'h0);
      ck(OFS_FLAGS, 32'h0);
      ck(OFS_PC, 32'h0);
      ck(ra(5), 32'h0);
      wr(8'h20, $urandom);
      ck(8'h20, 32'h0);
      $display("reset and map test done");
      for (int i = 0; i < 24; i++) begin
         fl = 8'($urandom);
         pc0 = 16'($urandom);
         k = 7'($urandom);
         wr(OFS_FLAGS, {24'h0, fl});
         wr(OFS_PC, {16'h0, pc0});
         exec({5'b11110, 1'((i / 6) % 2), k, bl[i % 6]});
         tk = ((bl[i % 6] == 3'd4) ? fl[FLG_N] ^ fl[FLG_V] : fl[bl[i % 6]]) ^ 1'((i / 6) % 2);
         pc = tk ? pc0 + {{9{k[6]}}, k} + 16'h1 : pc0 + 16'h1;
         ck(OFS_PC, {16'h0, pc});
         ck(OFS_STATUS, {30'h0, tk, 1'b0});
         ck(OFS_FLAGS, {24'h0, fl});
      end
      $display("branch test done");
      for (int i = 0; i < 4; i++) begin
         rs = $urandom_range(0, 12);
         v = 8'($urandom);
         v2 = 8'($urandom);
         wreg(rs, v);
         exec({6'b001011, 1'(rs >> 4), 5'(rs + 13), 4'(rs)});
         ck(ra(rs + 13), {24'h0, v});
         wreg(rs / 2 * 2, v);
         wreg(rs / 2 * 2 + 1, v2);
         exec({8'h01, 4'(rs / 2 + 6), 4'(rs / 2)});
         ck(ra(rs / 2 * 2 + 12), {24'h0, v});
         ck(ra(rs / 2 * 2 + 13), {24'h0, v2});
         exec({4'hE, v2[7:4], 4'(rs), v2[3:0]});
         ck(ra(rs + 16), {24'h0, v2});
      end
      exec(16'h0000);
      ck(OFS_STATUS, 32'h4);
      $display("copy and constant test done");
      for (int i = 0; i < 9; i++) begin
         a = 16'($urandom);
         v = 8'($urandom);
         qd = 6'($urandom);
         rs = $urandom_range(0, 12);
         dd = rs + 13;
         p = pk[i];
         wreg(p, a[7:0]);
         wreg(p + 1, a[15:8]);
         wreg(rs, v);
         op = (i < 7) ? {7'b1001001, 5'(rs), mc[i]} :
              {2'b10, qd[5], 1'b0, qd[4:3], 1'b1, 5'(rs), 1'(i == 7), qd[2:0]};
         ea = (md[i] == 2) ? a - 16'h1 : ((i >= 7) ? a + {10'h0, qd} : a);
         np = (md[i] == 1) ? a + 16'h1 : ((md[i] == 2) ? a - 16'h1 : a);
         mq.push_back({4'd2, 1'b1, ea, v});
         exec(op);
         ck(ra(p), {24'h0, np[7:0]});
         ck(ra(p + 1), {24'h0, np[15:8]});
         wreg(p, a[7:0]);
         wreg(p + 1, a[15:8]);
         mq.push_back({4'd2, 1'b0, ea, 8'h00});
         exec({op[15:10], 1'b0, 5'(dd), op[3:0]});
         ck(ra(dd), {24'h0, v});
         ck(ra(p), {24'h0, np[7:0]});
      end
      $display("pointer load and store test done");
      complete_run();
   end
endmodule // tb
`default_nettype wire
